//--- pkg/mws_consts.svh
// Offsets, field positions, reset values and scaling counts of the waveform sampler.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef MWS_CONSTS_SVH
`define MWS_CONSTS_SVH

// ****************************************
// Register offsets on the extended SFR port
// ****************************************
`define MWS_ADDR_W 9
`define MWS_ADDR_SEL 9'h1D2
`define MWS_ADDR_R1L 9'h1D3
`define MWS_ADDR_R1M 9'h1D4
`define MWS_ADDR_R1H 9'h1D5
`define MWS_ADDR_R2L 9'h1D6
`define MWS_ADDR_R2M 9'h1D7
`define MWS_ADDR_R2H 9'h1D8

// ****************************************
// Field layout and reset values
// ****************************************
`define MWS_SEL_RST 8'h00
`define MWS_SEL_MASK 8'h77
`define MWS_SLOT1_LSB 0
`define MWS_SLOT2_LSB 4
`define MWS_RES_RST 24'h000000
`define MWS_RDATA_RST 8'h00
`define MWS_APP_MAX 24'h7FFFFF

// ****************************************
// Datapath scaling
// ****************************************
`define MWS_PROD_SHIFT 23
`define MWS_GAIN_SHIFT 15
`define MWS_LEAK_SHIFT 10
`define MWS_INT_SHIFT 4
`define MWS_POLE_SHIFT 6
`define MWS_FREQ_SHIFT 12

`endif

//--- pkg/mws_pkg.sv
// Types shared by the waveform sampler files.
// Assumes nothing of its surroundings.
package mws_pkg;

    // ****************************************
    // Source codes of a sampling slot
    // ****************************************
    typedef enum logic [2:0] {
        MWS_SRC_INT1 = 3'b000,
        MWS_SRC_INT2 = 3'b001,
        MWS_SRC_ACT1 = 3'b010,
        MWS_SRC_ACT2 = 3'b011,
        MWS_SRC_REA1 = 3'b100,
        MWS_SRC_REA2 = 3'b101,
        MWS_SRC_APP1 = 3'b110,
        MWS_SRC_APP2 = 3'b111
    } mws_src_t;

    typedef logic signed [23:0] mws_sample_t;

endpackage : mws_pkg

//--- rtl/mws_integrator.sv
// Leaky integrator restoring current from a di/dt sensor sample stream.
// Assumes din is valid in the cycle of sample_en and comes from sys_clk logic.
`timescale 1ns/100ps
`include "mws_consts.svh"

module mws_integrator #(
    parameter int LEAK_SHIFT = `MWS_LEAK_SHIFT,
    parameter int IN_SHIFT = `MWS_INT_SHIFT
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic sample_en,
    input wire logic enable,
    input wire mws_pkg::mws_sample_t din,
    output mws_pkg::mws_sample_t dout
);

    mws_pkg::mws_sample_t acc_ff;
    mws_pkg::mws_sample_t nxt_acc;
    logic signed [25:0] sum;

    if (LEAK_SHIFT < 1 || LEAK_SHIFT > 20 || IN_SHIFT < 0 || IN_SHIFT > 20)
    begin : g_bad_shift
        $error("mws_integrator: shift out of range");
    end

    // Leak keeps a DC offset on the sensor from winding the sum up
    assign sum = 26'(acc_ff) + 26'(din >>> IN_SHIFT) - 26'(acc_ff >>> LEAK_SHIFT);
    assign nxt_acc = enable ? sum[23:0] : din;
    assign dout = acc_ff;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            acc_ff <= `MWS_RES_RST;
        else if (sample_en)
            acc_ff <= nxt_acc;
    end

endmodule : mws_integrator

//--- rtl/mws_phase_shift.sv
// Single-pole low-pass 90 degree shifter with line-frequency gain correction.
// Assumes line_freq is a same-clock value from the power quality circuit.
`timescale 1ns/100ps
`include "mws_consts.svh"

module mws_phase_shift #(
    parameter int POLE_SHIFT = `MWS_POLE_SHIFT,
    parameter int FREQ_SHIFT = `MWS_FREQ_SHIFT
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic sample_en,
    input wire logic comp_disable,
    input wire logic [15:0] line_freq,
    input wire mws_pkg::mws_sample_t din,
    output mws_pkg::mws_sample_t dout
);

    mws_pkg::mws_sample_t lpf_ff;
    mws_pkg::mws_sample_t dout_ff;
    logic signed [24:0] diff;
    logic signed [40:0] comp;

    if (POLE_SHIFT < 1 || POLE_SHIFT > 20 || FREQ_SHIFT < 0 || FREQ_SHIFT > 16)
    begin : g_bad_shift
        $error("mws_phase_shift: shift out of range");
    end

    // Pole far below line frequency: about 90 degrees, falling 20 dB per decade
    assign diff = 25'(din) - 25'(lpf_ff);
    // Correction is exact only at the line frequency itself
    assign comp = 41'(lpf_ff) * $signed({1'b0, line_freq});

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lpf_ff <= `MWS_RES_RST;
            dout_ff <= `MWS_RES_RST;
        end
        else if (sample_en)
        begin
            lpf_ff <= lpf_ff + 24'(diff >>> POLE_SHIFT);
            dout_ff <= comp_disable ? lpf_ff : comp[FREQ_SHIFT +: 24];
        end
    end

    assign dout = dout_ff;

    comp_bypass_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        sample_en && comp_disable |=> dout == $past(lpf_ff))
        else $error("compensation not bypassed");

endmodule : mws_phase_shift

//--- rtl/mws_sampler.sv
// Waveform sampler: source selector, two 24-bit result slots, integrators,
// phase shifter and gained power products.
// Assumes all inputs come from sys_clk logic and sample_strobe is a one-cycle
// pulse per internal sample period.
`timescale 1ns/100ps
`include "mws_consts.svh"

module mws_sampler #(
    parameter int LEAK_SHIFT = `MWS_LEAK_SHIFT,
    parameter int IN_SHIFT = `MWS_INT_SHIFT,
    parameter int POLE_SHIFT = `MWS_POLE_SHIFT,
    parameter int FREQ_SHIFT = `MWS_FREQ_SHIFT
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic xsfr_wr,
    input wire logic xsfr_rd,
    input wire logic [8:0] xsfr_addr,
    input wire logic [7:0] xsfr_wdata,
    output logic [7:0] xsfr_rdata,
    input wire logic sample_strobe,
    input wire mws_pkg::mws_sample_t current_one_in,
    input wire mws_pkg::mws_sample_t current_two_in,
    input wire mws_pkg::mws_sample_t voltage_one_in,
    input wire mws_pkg::mws_sample_t voltage_two_in,
    input wire logic integrator_one_enable,
    input wire logic integrator_two_enable,
    input wire logic reactive_comp_disable,
    input wire logic [15:0] line_freq,
    input wire logic [15:0] active_gain_one,
    input wire logic [15:0] active_gain_two,
    input wire logic [15:0] reactive_gain_one,
    input wire logic [15:0] reactive_gain_two,
    input wire logic [15:0] apparent_gain_one,
    input wire logic [15:0] apparent_gain_two
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic mws_pkg::mws_sample_t prod_f(input mws_pkg::mws_sample_t a,
                                                   input mws_pkg::mws_sample_t b);
        logic signed [47:0] p;
        p = 48'(a) * 48'(b);
        return p[`MWS_PROD_SHIFT +: 24];
    endfunction : prod_f

    // Gain is unsigned, unity at 8000H
    function automatic mws_pkg::mws_sample_t gain_f(input mws_pkg::mws_sample_t a,
                                                   input logic [15:0] g);
        logic signed [40:0] p;
        p = 41'(a) * $signed({1'b0, g});
        return p[`MWS_GAIN_SHIFT +: 24];
    endfunction : gain_f

    // Magnitude estimate max + min/2; cheap, never low and up to about 12 percent high
    function automatic mws_pkg::mws_sample_t mag_f(input mws_pkg::mws_sample_t p,
                                                  input mws_pkg::mws_sample_t q);
        logic [24:0] ap;
        logic [24:0] aq;
        logic [24:0] s;
        ap = p[23] ? 25'(-p) : 25'(p);
        aq = q[23] ? 25'(-q) : 25'(q);
        s = (ap > aq) ? ap + (aq >> 1) : aq + (ap >> 1);
        return (s > 25'(`MWS_APP_MAX)) ? `MWS_APP_MAX : s[23:0];
    endfunction : mag_f

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] sel_ff;
    mws_pkg::mws_sample_t res1_ff;
    mws_pkg::mws_sample_t res2_ff;
    logic [7:0] rdata_ff;
    logic capture_ff;
    mws_pkg::mws_sample_t v1_ff;
    mws_pkg::mws_sample_t v2_ff;

    wire sel_wr = xsfr_wr && (xsfr_addr == `MWS_ADDR_SEL);
    wire [7:0] nxt_sel = xsfr_wdata & `MWS_SEL_MASK;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            sel_ff <= `MWS_SEL_RST;
        else if (sel_wr)
            sel_ff <= nxt_sel;
    end

    wire mws_pkg::mws_src_t slot_one_source =
        mws_pkg::mws_src_t'(sel_ff[`MWS_SLOT1_LSB +: 3]);
    wire mws_pkg::mws_src_t slot_two_source =
        mws_pkg::mws_src_t'(sel_ff[`MWS_SLOT2_LSB +: 3]);

    // ****************************************
    // Integrators and phase shifters
    // ****************************************
    mws_pkg::mws_sample_t i1_out;
    mws_pkg::mws_sample_t i2_out;
    mws_pkg::mws_sample_t vs1_out;
    mws_pkg::mws_sample_t vs2_out;

    mws_integrator #(.LEAK_SHIFT(LEAK_SHIFT), .IN_SHIFT(IN_SHIFT)) u_int1 (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .sample_en(sample_strobe),
        .enable(integrator_one_enable),
        .din(current_one_in),
        .dout(i1_out)
    );

    mws_integrator #(.LEAK_SHIFT(LEAK_SHIFT), .IN_SHIFT(IN_SHIFT)) u_int2 (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .sample_en(sample_strobe),
        .enable(integrator_two_enable),
        .din(current_two_in),
        .dout(i2_out)
    );

    mws_phase_shift #(.POLE_SHIFT(POLE_SHIFT), .FREQ_SHIFT(FREQ_SHIFT)) u_ps1 (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .sample_en(sample_strobe),
        .comp_disable(reactive_comp_disable),
        .line_freq(line_freq),
        .din(voltage_one_in),
        .dout(vs1_out)
    );

    mws_phase_shift #(.POLE_SHIFT(POLE_SHIFT), .FREQ_SHIFT(FREQ_SHIFT)) u_ps2 (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .sample_en(sample_strobe),
        .comp_disable(reactive_comp_disable),
        .line_freq(line_freq),
        .din(voltage_two_in),
        .dout(vs2_out)
    );

    // Voltage held so that it lines up with the integrated current
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            v1_ff <= `MWS_RES_RST;
            v2_ff <= `MWS_RES_RST;
            capture_ff <= 1'b0;
        end
        else
        begin
            if (sample_strobe)
            begin
                v1_ff <= voltage_one_in;
                v2_ff <= voltage_two_in;
            end
            capture_ff <= sample_strobe;
        end
    end

    // ****************************************
    // Gained power products
    // ****************************************
    wire mws_pkg::mws_sample_t act1 = gain_f(prod_f(v1_ff, i1_out), active_gain_one);
    wire mws_pkg::mws_sample_t act2 = gain_f(prod_f(v2_ff, i2_out), active_gain_two);
    wire mws_pkg::mws_sample_t rea1 = gain_f(prod_f(vs1_out, i1_out), reactive_gain_one);
    wire mws_pkg::mws_sample_t rea2 = gain_f(prod_f(vs2_out, i2_out), reactive_gain_two);
    wire mws_pkg::mws_sample_t app1 =
        gain_f(mag_f(prod_f(v1_ff, i1_out), prod_f(vs1_out, i1_out)), apparent_gain_one);
    wire mws_pkg::mws_sample_t app2 =
        gain_f(mag_f(prod_f(v2_ff, i2_out), prod_f(vs2_out, i2_out)), apparent_gain_two);

    function automatic mws_pkg::mws_sample_t pick_f(input mws_pkg::mws_src_t s,
        input mws_pkg::mws_sample_t w0, input mws_pkg::mws_sample_t w1,
        input mws_pkg::mws_sample_t w2, input mws_pkg::mws_sample_t w3,
        input mws_pkg::mws_sample_t w4, input mws_pkg::mws_sample_t w5,
        input mws_pkg::mws_sample_t w6, input mws_pkg::mws_sample_t w7);
        mws_pkg::mws_sample_t r;
        r = w0;
        unique case (s)
            mws_pkg::MWS_SRC_INT1: r = w0;
            mws_pkg::MWS_SRC_INT2: r = w1;
            mws_pkg::MWS_SRC_ACT1: r = w2;
            mws_pkg::MWS_SRC_ACT2: r = w3;
            mws_pkg::MWS_SRC_REA1: r = w4;
            mws_pkg::MWS_SRC_REA2: r = w5;
            mws_pkg::MWS_SRC_APP1: r = w6;
            mws_pkg::MWS_SRC_APP2: r = w7;
        endcase
        return r;
    endfunction : pick_f

    wire mws_pkg::mws_sample_t nxt_res1 =
        pick_f(slot_one_source, i1_out, i2_out, act1, act2, rea1, rea2, app1, app2);
    wire mws_pkg::mws_sample_t nxt_res2 =
        pick_f(slot_two_source, i1_out, i2_out, act1, act2, rea1, rea2, app1, app2);

    // ****************************************
    // Result slots and read port
    // ****************************************
    // Writes to result addresses fall through: the slots are read-only
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            res1_ff <= `MWS_RES_RST;
            res2_ff <= `MWS_RES_RST;
        end
        else if (capture_ff)
        begin
            res1_ff <= nxt_res1;
            res2_ff <= nxt_res2;
        end
    end

    // Bytes are not snapshotted: a read across a refresh can tear the word
    logic [7:0] rd_mux;
    always_comb
    begin
        rd_mux = `MWS_RDATA_RST;
        unique case (xsfr_addr)
            `MWS_ADDR_SEL: rd_mux = sel_ff;
            `MWS_ADDR_R1L: rd_mux = res1_ff[7:0];
            `MWS_ADDR_R1M: rd_mux = res1_ff[15:8];
            `MWS_ADDR_R1H: rd_mux = res1_ff[23:16];
            `MWS_ADDR_R2L: rd_mux = res2_ff[7:0];
            `MWS_ADDR_R2M: rd_mux = res2_ff[15:8];
            `MWS_ADDR_R2H: rd_mux = res2_ff[23:16];
            default: rd_mux = `MWS_RDATA_RST;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            rdata_ff <= `MWS_RDATA_RST;
        else if (xsfr_rd)
            rdata_ff <= rd_mux;
    end

    assign xsfr_rdata = rdata_ff;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sel_store_a: assert property (
        sel_wr |=> sel_ff == ($past(xsfr_wdata) & `MWS_SEL_MASK))
        else $error("selector did not store masked write");

    src_int_a: assert property (
        capture_ff && slot_one_source == mws_pkg::MWS_SRC_INT2 |=> res1_ff == $past(i2_out))
        else $error("slot one missed integrator two");

    src_act_a: assert property (
        capture_ff && slot_one_source == mws_pkg::MWS_SRC_ACT1 |=> res1_ff == $past(act1))
        else $error("slot one missed active power one");

    src_rea_a: assert property (
        capture_ff && slot_two_source == mws_pkg::MWS_SRC_REA2 |=> res2_ff == $past(rea2))
        else $error("slot two missed reactive power two");

    src_app_a: assert property (
        capture_ff && slot_two_source == mws_pkg::MWS_SRC_APP2 |=> res2_ff == $past(app2))
        else $error("slot two missed apparent power two");

    res_hold_a: assert property (
        !capture_ff |=> $stable(res1_ff) && $stable(res2_ff))
        else $error("result changed outside a capture");

    read_map_a: assert property (
        xsfr_rd && xsfr_addr == `MWS_ADDR_R2M |=> xsfr_rdata == $past(res2_ff[15:8]))
        else $error("middle byte of slot two misread");

    refresh_a: assert property (
        sample_strobe ##1 capture_ff && slot_one_source == mws_pkg::MWS_SRC_INT1
            |=> res1_ff == $past(i1_out))
        else $error("slot one not refreshed after strobe");

    bypass_a: assert property (
        sample_strobe && !integrator_one_enable |=> i1_out == $past(current_one_in))
        else $error("disabled integrator not bypassed");

    slot_two_int_a: assert property (
        capture_ff && slot_two_source == mws_pkg::MWS_SRC_INT1 |=> res2_ff == $past(i1_out))
        else $error("slot two missed integrator one");

    slot_two_act_a: assert property (
        capture_ff && slot_two_source == mws_pkg::MWS_SRC_ACT2 |=> res2_ff == $past(act2))
        else $error("slot two missed active power two");

    slot_one_rea_a: assert property (
        capture_ff && slot_one_source == mws_pkg::MWS_SRC_REA1 |=> res1_ff == $past(rea1))
        else $error("slot one missed reactive power one");

    slot_one_app_a: assert property (
        capture_ff && slot_one_source == mws_pkg::MWS_SRC_APP1 |=> res1_ff == $past(app1))
        else $error("slot one missed apparent power one");

    sel_keep_a: assert property (
        !sel_wr |=> $stable(sel_ff))
        else $error("selector changed without its own write");

    rdata_hold_a: assert property (
        !xsfr_rd |=> $stable(xsfr_rdata))
        else $error("read data changed without a read");

    bypass_two_a: assert property (
        sample_strobe && !integrator_two_enable |=> i2_out == $past(current_two_in))
        else $error("disabled integrator two not bypassed");

    int_hold_a: assert property (
        !sample_strobe |=> $stable(i1_out) && $stable(i2_out))
        else $error("integrator moved between samples");

    volt_latch_a: assert property (
        sample_strobe |=> v1_ff == $past(voltage_one_in) && v2_ff == $past(voltage_two_in))
        else $error("voltage not latched on strobe");

    cov_int_c: cover property (sample_strobe && integrator_one_enable ##1 capture_ff);
    cov_sel_c: cover property (sel_wr ##[1:20] capture_ff);
    cov_rd_c: cover property (capture_ff ##[1:20] xsfr_rd && xsfr_addr == `MWS_ADDR_R1H);
    cov_nocomp_c: cover property (sample_strobe && reactive_comp_disable);
    cov_app_c: cover property (capture_ff && slot_two_source == mws_pkg::MWS_SRC_APP2);

endmodule : mws_sampler

//--- verification/mws_sampler_tb_top.sv
// Self-checking bench for the waveform sampler: register port, slot sources, integrators,
// phase shifter gain correction.
// Assumes mws_pkg and mws_consts.svh are on the compile path; no partner model.
`timescale 1ns/100ps
`include "mws_consts.svh"

module mws_sampler_tb_top;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic xsfr_wr = 1'b0;
    logic xsfr_rd = 1'b0;
    logic [8:0] xsfr_addr = 9'h000;
    logic [7:0] xsfr_wdata = 8'h00;
    logic [7:0] xsfr_rdata;
    logic sample_strobe = 1'b0;
    mws_pkg::mws_sample_t cur1 = 24'h000000;
    mws_pkg::mws_sample_t cur2 = 24'h000000;
    mws_pkg::mws_sample_t volt1 = 24'h400000;
    mws_pkg::mws_sample_t volt2 = 24'h400000;
    logic int1_en = 1'b0;
    logic int2_en = 1'b0;
    logic comp_dis = 1'b1;
    logic [15:0] line_freq = 16'h1000;
    // Channel one gains are unity, channel two gains half, so channel two reads half of channel one
    logic [15:0] gain_one = 16'h8000;
    logic [15:0] gain_two = 16'h4000;
    int num_errors = 0;
    int num_checks = 0;
    logic [23:0] r1, r2, ra;

    mws_sampler dut_u (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .xsfr_wr(xsfr_wr),
        .xsfr_rd(xsfr_rd),
        .xsfr_addr(xsfr_addr),
        .xsfr_wdata(xsfr_wdata),
        .xsfr_rdata(xsfr_rdata),
        .sample_strobe(sample_strobe),
        .current_one_in(cur1),
        .current_two_in(cur2),
        .voltage_one_in(volt1),
        .voltage_two_in(volt2),
        .integrator_one_enable(int1_en),
        .integrator_two_enable(int2_en),
        .reactive_comp_disable(comp_dis),
        .line_freq(line_freq),
        .active_gain_one(gain_one),
        .active_gain_two(gain_two),
        .reactive_gain_one(gain_one),
        .reactive_gain_two(gain_two),
        .apparent_gain_one(gain_one),
        .apparent_gain_two(gain_two)
    );

    always #50 sys_clk = ~sys_clk;

    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic step();
        @(posedge sys_clk);
        #10;
    endtask : step

    task automatic do_reset();
        nrst = 1'b0;
        repeat (8) step();
        nrst = 1'b1;
        step();
    endtask : do_reset

    task automatic reg_wr(input logic [8:0] a, input logic [7:0] d);
        xsfr_addr = a;
        xsfr_wdata = d;
        xsfr_wr = 1'b1;
        step();
        xsfr_wr = 1'b0;
        step();
    endtask : reg_wr

    // Data is taken one full cycle after the strobe edge, where it is settled and held
    task automatic reg_rd(input logic [8:0] a, output logic [7:0] d);
        xsfr_addr = a;
        xsfr_rd = 1'b1;
        step();
        xsfr_rd = 1'b0;
        step();
        d = xsfr_rdata;
    endtask : reg_rd

    // No strobe is issued while the three bytes are read, so they never tear
    task automatic read24(input logic [8:0] base, output logic [23:0] v);
        reg_rd(base, v[7:0]);
        reg_rd(base + 9'h001, v[15:8]);
        reg_rd(base + 9'h002, v[23:16]);
    endtask : read24

    task automatic pulse(input int n);
        repeat (n)
        begin
            sample_strobe = 1'b1;
            step();
            sample_strobe = 1'b0;
            repeat (3) step();
        end
    endtask : pulse

    task automatic fail(input string msg);
        num_errors++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask : fail

    task automatic check8(input logic [8:0] a, input logic [7:0] exp);
        logic [7:0] d;
        reg_rd(a, d);
        num_checks++;
        if (d !== exp)
            fail($sformatf("byte at %h read %h, expected %h", a, d, exp));
    endtask : check8

    task automatic check24(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp)
            fail($sformatf("result %h, expected %h", got, exp));
    endtask : check24

    task automatic check_ok(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1)
            fail(msg);
    endtask : check_ok

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset_values();
        for (int a = `MWS_ADDR_SEL; a <= `MWS_ADDR_R2H; a++)
            check8(a[8:0], 8'h00);
        check8(9'h1D9, 8'h00);
    endtask : t_reset_values

    task automatic t_selector();
        reg_wr(`MWS_ADDR_SEL, 8'hFF);
        check8(`MWS_ADDR_SEL, 8'h77);
        reg_wr(`MWS_ADDR_R1L, 8'hAA);
        reg_wr(`MWS_ADDR_R2H, 8'h55);
        check8(`MWS_ADDR_R1L, 8'h00);
        check8(`MWS_ADDR_R2H, 8'h00);
        reg_wr(`MWS_ADDR_SEL, 8'h21);
        reg_wr(`MWS_ADDR_SEL, 8'h35);
        check8(`MWS_ADDR_SEL, 8'h35);
    endtask : t_selector

    task automatic t_bypass();
        do_reset();
        reg_wr(`MWS_ADDR_SEL, 8'h10);
        cur1 = 24'h123456;
        cur2 = 24'hFFFFFB;
        pulse(1);
        read24(`MWS_ADDR_R1L, r1);
        read24(`MWS_ADDR_R2L, r2);
        check24(r1, 24'h123456);
        check24(r2, 24'hFFFFFB);
        // Inputs move without a strobe: results must hold
        cur1 = 24'h0ABCDE;
        repeat (5) step();
        read24(`MWS_ADDR_R1L, r1);
        check24(r1, 24'h123456);
        reg_wr(`MWS_ADDR_SEL, 8'h01);
        pulse(1);
        read24(`MWS_ADDR_R1L, r1);
        read24(`MWS_ADDR_R2L, r2);
        check24(r1, 24'hFFFFFB);
        check24(r2, 24'h0ABCDE);
        do_reset();
        check8(`MWS_ADDR_R2L, 8'h00);
        check8(`MWS_ADDR_SEL, 8'h00);
    endtask : t_bypass

    task automatic t_integrate();
        do_reset();
        reg_wr(`MWS_ADDR_SEL, 8'h10);
        cur1 = 24'h010000;
        cur2 = 24'h010000;
        int1_en = 1'b1;
        pulse(1);
        read24(`MWS_ADDR_R1L, r1);
        read24(`MWS_ADDR_R2L, r2);
        check24(r1, 24'h001000);
        check24(r2, 24'h010000);
        int2_en = 1'b1;
        pulse(1);
        read24(`MWS_ADDR_R1L, r1);
        read24(`MWS_ADDR_R2L, r2);
        check24(r1, 24'h001FFC);
        check24(r2, 24'h010FC0);
        int1_en = 1'b0;
        int2_en = 1'b0;
    endtask : t_integrate

    task automatic t_active();
        do_reset();
        reg_wr(`MWS_ADDR_SEL, 8'h32);
        cur1 = 24'h200000;
        cur2 = 24'h200000;
        pulse(2);
        read24(`MWS_ADDR_R1L, r1);
        read24(`MWS_ADDR_R2L, r2);
        check24(r1, 24'h100000);
        check24(r2, 24'h080000);
    endtask : t_active

    // Both channels see the same inputs, so slot two must be slot one scaled by its gain
    task automatic t_pair(input logic [7:0] sel, input logic [23:0] exp1);
        do_reset();
        reg_wr(`MWS_ADDR_SEL, sel);
        cur1 = 24'h200000;
        cur2 = 24'h200000;
        pulse(3);
        read24(`MWS_ADDR_R1L, r1);
        read24(`MWS_ADDR_R2L, r2);
        check_ok(r1 !== 24'h000000, "channel one power stayed zero");
        check24(r1, exp1);
        check24(r2, {1'b0, r1[23:1]});
    endtask : t_pair

    task automatic t_comp();
        do_reset();
        reg_wr(`MWS_ADDR_SEL, 8'h44);
        cur1 = 24'h400000;
        comp_dis = 1'b1;
        line_freq = 16'h2000;
        pulse(3);
        read24(`MWS_ADDR_R1L, ra);
        do_reset();
        reg_wr(`MWS_ADDR_SEL, 8'h44);
        comp_dis = 1'b0;
        pulse(3);
        read24(`MWS_ADDR_R1L, r1);
        // Twice the line frequency scale doubles the shifted value, up to one lsb of rounding
        check_ok(ra !== 24'h000000, "shifted power stayed zero");
        check24(ra, 24'h00FE00);
        check_ok(r1 === (ra << 1) || r1 === ((ra << 1) + 24'h1), "correction gain wrong");
        check24(r1, 24'h01FC00);
        comp_dis = 1'b1;
        line_freq = 16'h1000;
    endtask : t_comp

    // ****************************************
    // Sequence, watchdog and verdict
    // ****************************************
    task automatic stop_test();
        $display("Checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    initial
    begin
        do_reset();
        t_reset_values();
        t_selector();
        t_bypass();
        t_integrate();
        t_active();
        t_pair(8'h54, 24'h007F00);
        t_pair(8'h76, 24'h103F80);
        t_comp();
        stop_test();
    end

    // The sequence needs well under 2000 cycles; ten times that marks a hang
    initial
    begin
        #2000000;
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        stop_test();
    end
endmodule : mws_sampler_tb_top
